// File: src/dcp_top.sv
// serial control port and program registers of a stereo audio dac
// assumes a host drives the three-wire port and the audio clocks;
// control_clock_in clocks control_data_in into the shadow, the rest is sampled on clk
`timescale 1ns/100ps
`default_nettype none
`include "dcp_map.svh"

module dcp_top #(
	parameter int RATIO_CNT_W = 10,
	parameter logic [3:0] RESYNC_FRAMES = `DCP_RESYNC_FRAMES
) (
	// system clock domain
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// audio clocks from the host
	input wire logic system_clock_in,
	input wire logic word_clock_in,
	// three-wire control port
	input wire logic control_clock_in,
	input wire logic control_data_in,
	input wire logic control_latch_in,
	// applied channel gains, 256 is unity
	output logic [8:0] left_gain_code,
	output logic [8:0] right_gain_code,
	output logic level_update,
	// mute, routing and word length controls
	output logic soft_silence,
	output logic emphasis_filter_on,
	output logic output_force_zero,
	output logic [1:0] word_length_sel,
	output logic [3:0] channel_route_sel,
	// format, rate and zero detect controls
	output logic audio_format_sel,
	output logic word_clock_invert,
	output logic common_gain_sel,
	output logic [1:0] rate_family_sel,
	output logic zero_detect_en,
	// clock tracking state
	output logic clock_ratio_sel,
	output logic midscale_output,
	output logic left_channel_now
);

	// ---------------- link domain: shadow shift register ----------------
	logic [`DCP_WORD_W-1:0] shadow_word;

	// only the link clock touches the shadow; the program registers
	// stay put until a latch is seen on clk
	always_ff @(posedge control_clock_in or posedge rst) begin
		if (rst) begin
			shadow_word <= '0;
		end else begin
			shadow_word <= {shadow_word[`DCP_WORD_W-2:0], control_data_in};
		end
	end

	// ---------------- pin synchronisers ----------------
	logic latch_lvl;
	logic wclk_lvl;
	logic sclk_lvl;

	dcp_sync3 u_sync_latch (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(control_latch_in),
		.q(latch_lvl)
	);

	dcp_sync3 u_sync_wclk (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(word_clock_in),
		.q(wclk_lvl)
	);

	dcp_sync3 u_sync_sclk (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(system_clock_in),
		.q(sclk_lvl)
	);

	logic latch_prev;
	logic wclk_prev;
	logic sclk_prev;
	logic latch_rise;
	logic wclk_rise;
	logic sclk_rise;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_prev <= 1'b0;
			wclk_prev <= 1'b0;
			sclk_prev <= 1'b0;
		end else if (ce) begin
			latch_prev <= latch_lvl;
			wclk_prev <= wclk_lvl;
			sclk_prev <= sclk_lvl;
		end
	end

	assign latch_rise = ce && latch_lvl && !latch_prev;
	assign wclk_rise = ce && wclk_lvl && !wclk_prev;
	assign sclk_rise = ce && sclk_lvl && !sclk_prev;

	// ---------------- latch: word transfer ----------------
	// the host holds the control clock still around the latch, so the
	// shadow is stable for the four cycles the latch takes to cross
	logic [`DCP_WORD_W-1:0] word_in;
	dcp_pkg::dcp_reg_sel_t word_sel;
	logic [`DCP_DATA_W-1:0] word_data;

	assign word_in = shadow_word;
	assign word_sel = dcp_pkg::dcp_reg_sel_t'(
		word_in[`DCP_SEL_HI:`DCP_SEL_LO]);
	assign word_data = word_in[`DCP_DATA_W-1:0];

	logic [7:0] left_step;
	logic [7:0] right_step;
	logic left_load;
	logic right_load;
	logic load_any;

	assign left_load = latch_rise && (word_sel == dcp_pkg::DCP_REG_LEFT)
		&& word_data[`DCP_ATT_LOAD];
	assign right_load = latch_rise && (word_sel == dcp_pkg::DCP_REG_RIGHT)
		&& word_data[`DCP_ATT_LOAD];
	assign load_any = left_load || right_load;

	// attenuation steps are stored on every latch to their own register, load flag or not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_step <= `DCP_ATT_FULL;
			right_step <= `DCP_ATT_FULL;
		end else if (latch_rise) begin
			case (word_sel)
				dcp_pkg::DCP_REG_LEFT: begin
					left_step <= word_data[`DCP_ATT_MSB:`DCP_ATT_LSB];
				end
				dcp_pkg::DCP_REG_RIGHT: begin
					right_step <= word_data[`DCP_ATT_MSB:`DCP_ATT_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------- step to gain ----------------
	function automatic logic [8:0] step_to_gain(input logic [7:0] x);
		if (x == `DCP_ATT_FULL) begin
			step_to_gain = `DCP_GAIN_UNITY;
		end else begin
			step_to_gain = {1'b0, x};
		end
	endfunction

	// the step being written this cycle counts, not the stale one
	logic [7:0] next_left_step;
	logic [7:0] next_right_step;
	logic [7:0] right_source;

	always_comb begin
		next_left_step = left_step;
		next_right_step = right_step;
		if (latch_rise && word_sel == dcp_pkg::DCP_REG_LEFT) begin
			next_left_step = word_data[`DCP_ATT_MSB:`DCP_ATT_LSB];
		end
		if (latch_rise && word_sel == dcp_pkg::DCP_REG_RIGHT) begin
			next_right_step = word_data[`DCP_ATT_MSB:`DCP_ATT_LSB];
		end
	end

	// common mode takes the left step for both channels
	assign right_source = common_gain_sel ? next_left_step : next_right_step;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_gain_code <= `DCP_GAIN_UNITY;
			right_gain_code <= `DCP_GAIN_UNITY;
		end else if (load_any) begin
			left_gain_code <= step_to_gain(next_left_step);
			right_gain_code <= step_to_gain(right_source);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_update <= 1'b0;
		end else if (ce) begin
			level_update <= load_any;
		end
	end

	// ---------------- mute / routing / word length register ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			soft_silence <= 1'b0;
			emphasis_filter_on <= 1'b0;
			output_force_zero <= 1'b0;
			word_length_sel <= `DCP_WLEN_16;
			channel_route_sel <= `DCP_ROUTE_STEREO;
		end else if (latch_rise && word_sel == dcp_pkg::DCP_REG_MUTE) begin
			soft_silence <= word_data[`DCP_MUTE_BIT];
			emphasis_filter_on <= word_data[`DCP_EMPH_BIT];
			output_force_zero <= word_data[`DCP_FORCE_BIT];
			word_length_sel <= word_data[`DCP_WLEN_MSB:`DCP_WLEN_LSB];
			channel_route_sel <= word_data[`DCP_ROUTE_MSB:`DCP_ROUTE_LSB];
		end
	end

	// ---------------- format / rate / zero detect register ----------------
	// rate code 11 is stored as written; its meaning is left undefined
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			audio_format_sel <= 1'b0;
			word_clock_invert <= 1'b0;
			common_gain_sel <= 1'b0;
			rate_family_sel <= `DCP_RATE_441;
			zero_detect_en <= 1'b0;
		end else if (latch_rise && word_sel == dcp_pkg::DCP_REG_FORMAT) begin
			audio_format_sel <= word_data[`DCP_FMT_BIT];
			word_clock_invert <= word_data[`DCP_INV_BIT];
			common_gain_sel <= word_data[`DCP_COMMON_BIT];
			rate_family_sel <= word_data[`DCP_RATE_MSB:`DCP_RATE_LSB];
			zero_detect_en <= word_data[`DCP_ZDET_BIT];
		end
	end

	// ---------------- channel phase of the word clock ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_channel_now <= 1'b0;
		end else if (ce) begin
			left_channel_now <= wclk_lvl ^ word_clock_invert;
		end
	end

	// ---------------- clock ratio detection ----------------
	// counts system clock edges per word clock period; 320 splits the two
	logic [RATIO_CNT_W-1:0] ratio_cnt;
	dcp_pkg::dcp_lock_t lock_state;
	dcp_pkg::dcp_lock_t next_lock_state;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ratio_cnt <= '0;
		end else if (wclk_rise) begin
			ratio_cnt <= '0;
		end else if (sclk_rise && !(&ratio_cnt)) begin
			ratio_cnt <= ratio_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clock_ratio_sel <= 1'b1;
		// the count up to the first edge after reset covers a partial period
		end else if (wclk_rise
			&& lock_state != dcp_pkg::DCP_LOCK_SEARCH) begin
			clock_ratio_sel <= (ratio_cnt > `DCP_RATIO_SPLIT);
		end
	end

	// ---------------- frame position and phase check ----------------
	logic [8:0] frame_len;
	logic [8:0] frame_pos;
	logic [8:0] phase_dist;
	logic [8:0] phase_limit;
	logic phase_bad;

	assign frame_len = clock_ratio_sel ? `DCP_RATIO_384 : `DCP_RATIO_256;
	// six bit clocks, with 64 bit clocks to a frame, in system clocks
	assign phase_limit = 9'((32'(frame_len) * `DCP_PHASE_LIMIT_BITS)
		/ `DCP_BITS_PER_FRAME);
	assign phase_dist = (frame_pos < {1'b0, frame_len[8:1]}) ? frame_pos
		: 9'(frame_len - frame_pos);
	assign phase_bad = phase_dist > phase_limit;

	logic [3:0] hold_cnt;
	logic start_resync;

	assign start_resync = wclk_rise && (lock_state == dcp_pkg::DCP_LOCK_SEARCH
		|| (lock_state == dcp_pkg::DCP_LOCK_TRACK && phase_bad));

	// internal frame timing follows every word clock edge until tracking,
	// so the phase check starts aligned even if the ratio changed meanwhile
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_pos <= '0;
		end else if (start_resync || (wclk_rise
			&& lock_state != dcp_pkg::DCP_LOCK_TRACK)) begin
			frame_pos <= '0;
		end else if (sclk_rise) begin
			if (frame_pos >= frame_len - 9'h001) begin
				frame_pos <= '0;
			end else begin
				frame_pos <= frame_pos + 9'h001;
			end
		end
	end

	always_comb begin
		next_lock_state = lock_state;
		case (lock_state)
			dcp_pkg::DCP_LOCK_SEARCH: begin
				if (wclk_rise) begin
					next_lock_state = dcp_pkg::DCP_LOCK_RESYNC;
				end
			end
			dcp_pkg::DCP_LOCK_RESYNC: begin
				if (wclk_rise && hold_cnt == 4'h0) begin
					next_lock_state = dcp_pkg::DCP_LOCK_TRACK;
				end
			end
			dcp_pkg::DCP_LOCK_TRACK: begin
				if (start_resync) begin
					next_lock_state = dcp_pkg::DCP_LOCK_RESYNC;
				end
			end
			default: begin
				next_lock_state = dcp_pkg::DCP_LOCK_SEARCH;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_state <= dcp_pkg::DCP_LOCK_SEARCH;
		end else if (ce) begin
			lock_state <= next_lock_state;
		end
	end

	// a few whole frames of quiet cover the filter refilling after the jump
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_cnt <= '0;
		end else if (start_resync) begin
			hold_cnt <= RESYNC_FRAMES;
		end else if (wclk_rise && hold_cnt != 4'h0) begin
			hold_cnt <= hold_cnt - 4'h1;
		end
	end

	// outputs sit at midscale until tracking, and when forced to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			midscale_output <= 1'b1;
		end else if (ce) begin
			midscale_output <= (next_lock_state != dcp_pkg::DCP_LOCK_TRACK)
				|| output_force_zero;
		end
	end

endmodule

`default_nettype wire

// File: src/dcp_map.svh
// constants of the dac control port: field positions, reset values, counts
// assumes inclusion by bare name from the design files
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH

// program word layout
`define DCP_WORD_W 16
`define DCP_SEL_HI 10
`define DCP_SEL_LO 9
`define DCP_DATA_W 9

// register select codes
`define DCP_SEL_LEFT 2'h0
`define DCP_SEL_RIGHT 2'h1
`define DCP_SEL_MUTE 2'h2
`define DCP_SEL_FORMAT 2'h3

// attenuation registers
`define DCP_ATT_LSB 0
`define DCP_ATT_MSB 7
`define DCP_ATT_LOAD 8
`define DCP_ATT_FULL 8'hFF
`define DCP_GAIN_UNITY 9'h100

// mute / routing / word length register
`define DCP_MUTE_BIT 0
`define DCP_EMPH_BIT 1
`define DCP_FORCE_BIT 2
`define DCP_WLEN_LSB 3
`define DCP_WLEN_MSB 4
`define DCP_ROUTE_LSB 5
`define DCP_ROUTE_MSB 8
`define DCP_ROUTE_STEREO 4'h9
`define DCP_WLEN_16 2'h0
`define DCP_WLEN_20 2'h1
`define DCP_WLEN_24 2'h2

// format / rate / zero detect register
`define DCP_FMT_BIT 0
`define DCP_INV_BIT 1
`define DCP_COMMON_BIT 2
`define DCP_RATE_LSB 6
`define DCP_RATE_MSB 7
`define DCP_ZDET_BIT 8
`define DCP_RATE_441 2'h0
`define DCP_RATE_48 2'h1
`define DCP_RATE_32 2'h2

// clock ratio and resynchronisation
`define DCP_RATIO_256 9'h100
`define DCP_RATIO_384 9'h180
`define DCP_RATIO_SPLIT 10'h140
`define DCP_BITS_PER_FRAME 64
`define DCP_PHASE_LIMIT_BITS 6
`define DCP_RESYNC_FRAMES 4'h2

`endif

// File: src/dcp_pkg.sv
// types shared by the dac control port design
// assumes dcp_map.svh supplies the numeric constants
package dcp_pkg;

	typedef enum logic [1:0] {
		DCP_REG_LEFT,
		DCP_REG_RIGHT,
		DCP_REG_MUTE,
		DCP_REG_FORMAT
	} dcp_reg_sel_t;

	typedef enum logic [1:0] {
		DCP_LOCK_SEARCH,
		DCP_LOCK_RESYNC,
		DCP_LOCK_TRACK
	} dcp_lock_t;

endpackage

// File: src/dcp_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes d comes from outside the clk domain
`timescale 1ns/100ps
`default_nettype none

module dcp_sync3 (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// pin side
	input wire logic d,
	// filtered level
	output logic q
);

	logic stage1;
	logic stage2;
	logic stage3;

	// stage1 feeds stage2 alone; the filter only looks at stages 2 and 3
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else if (ce) begin
			stage1 <= d;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (ce && (stage2 == stage3)) begin
			q <= stage3;
		end
	end

endmodule

`default_nettype wire

// File: tb/dcp_assertions.sv
// port checks of the dac control port top
// assumes a bind to dcp_top; all checks run on clk
`timescale 1ns/100ps
`default_nettype none
module dcp_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// latch pin
	input wire logic control_latch_in,
	// gains
	input wire logic [8:0] left_gain_code,
	input wire logic [8:0] right_gain_code,
	input wire logic level_update,
	// register outputs
	input wire logic soft_silence,
	input wire logic emphasis_filter_on,
	input wire logic output_force_zero,
	input wire logic [1:0] word_length_sel,
	input wire logic [3:0] channel_route_sel,
	input wire logic audio_format_sel,
	input wire logic word_clock_invert,
	input wire logic common_gain_sel,
	input wire logic [1:0] rate_family_sel,
	input wire logic zero_detect_en,
	// tracking
	input wire logic midscale_output
);
	logic [8:0] r2;
	logic [5:0] r3;
	logic [17:0] gains;
	assign r2 = {channel_route_sel, word_length_sel, output_force_zero,
		emphasis_filter_on, soft_silence};
	assign r3 = {zero_detect_en, rate_family_sel, common_gain_sel,
		word_clock_invert, audio_format_sel};
	assign gains = {left_gain_code, right_gain_code};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_pulse;
		level_update ##1 !level_update;
	endsequence
	sequence s_latched;
		$past(control_latch_in, 4);
	endsequence
	property p_pulse;
		$rose(level_update) |-> s_pulse;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("level update pulse too long");
	property p_pair;
		gains != $past(gains) |-> level_update;
	endproperty
	a_pair: assert property (p_pair)
		else $error("gain change without level update");
	property p_range;
		left_gain_code <= 9'h100 && left_gain_code != 9'h0FF &&
			right_gain_code <= 9'h100 && right_gain_code != 9'h0FF;
	endproperty
	a_range: assert property (p_range)
		else $error("gain code outside the step law");
	property p_latch_only;
		{r2, r3, gains} != $past({r2, r3, gains}) |-> s_latched;
	endproperty
	a_latch_only: assert property (p_latch_only)
		else $error("register changed without a latch");
	property p_one_reg;
		r2 != $past(r2) |-> $stable(r3) && $stable(gains);
	endproperty
	a_one_reg: assert property (p_one_reg)
		else $error("one word changed two registers");
	property p_gain_apart;
		gains != $past(gains) |-> $stable(r2) && $stable(r3);
	endproperty
	a_gain_apart: assert property (p_gain_apart)
		else $error("gain and control changed together");
	property p_force;
		output_force_zero && $past(output_force_zero) |-> midscale_output;
	endproperty
	a_force: assert property (p_force)
		else $error("forced output not at midscale");
	property p_hold;
		$rose(midscale_output) && !output_force_zero |=>
			midscale_output [*8];
	endproperty
	a_hold: assert property (p_hold)
		else $error("midscale released too early");
endmodule
`default_nettype wire

// File: tb/dcp_host_model.sv
// host side of the three-wire control port
// assumes the caller waits for each task; link clock idles low
`timescale 1ns/100ps
`default_nettype none
module dcp_host_model (
	// three-wire control port
	output logic control_clock_in,
	output logic control_data_in,
	output logic control_latch_in
);
	initial begin
		control_clock_in = 1'b0;
		control_data_in = 1'b1;
		control_latch_in = 1'b0;
	end
	// 64 ns link clock, runs only inside a word
	task automatic shift(input logic [15:0] w, input int n);
		#5.3;
		for (int i = 15; i > 15 - n; i--) begin
			control_data_in = w[i];
			#16;
			control_clock_in = 1'b1;
			#32;
			control_clock_in = 1'b0;
			#16;
		end
		// released line goes to its pull-up
		control_data_in = 1'b1;
	endtask
	// clock stays still while the latch crossing copies the shadow
	task automatic latch();
		#20;
		control_latch_in = 1'b1;
		#40;
		control_latch_in = 1'b0;
		#40;
	endtask
	task automatic send(input logic [15:0] w);
		shift(w, 16);
		latch();
	endtask
endmodule
`default_nettype wire

// File: tb/dcp_top_test.sv
// self-checking bench of the dac control port top
// assumes dcp_host_model drives the port and this bench the audio clocks
`timescale 1ns/100ps
`default_nettype none
module dcp_top_test;
	logic clk, rst, ce, system_clock_in, word_clock_in;
	wire control_clock_in, control_data_in, control_latch_in;
	logic [8:0] left_gain_code, right_gain_code;
	logic level_update, soft_silence, emphasis_filter_on, output_force_zero;
	logic [1:0] word_length_sel, rate_family_sel;
	logic [3:0] channel_route_sel;
	logic audio_format_sel, word_clock_invert, common_gain_sel;
	logic zero_detect_en, clock_ratio_sel, midscale_output, left_channel_now;
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int ratio = 384;
	int wpos = 0;
	int jump = 0;
	logic [1:0] div = 2'h0;
	dcp_top i_dcp_top (.clk(clk), .rst(rst), .ce(ce),
		.system_clock_in(system_clock_in), .word_clock_in(word_clock_in),
		.control_clock_in(control_clock_in),
		.control_data_in(control_data_in),
		.control_latch_in(control_latch_in),
		.left_gain_code(left_gain_code), .right_gain_code(right_gain_code),
		.level_update(level_update), .soft_silence(soft_silence),
		.emphasis_filter_on(emphasis_filter_on),
		.output_force_zero(output_force_zero),
		.word_length_sel(word_length_sel),
		.channel_route_sel(channel_route_sel),
		.audio_format_sel(audio_format_sel),
		.word_clock_invert(word_clock_invert),
		.common_gain_sel(common_gain_sel), .rate_family_sel(rate_family_sel),
		.zero_detect_en(zero_detect_en), .clock_ratio_sel(clock_ratio_sel),
		.midscale_output(midscale_output),
		.left_channel_now(left_channel_now));
	dcp_host_model i_dcp_host_model (.control_clock_in(control_clock_in),
		.control_data_in(control_data_in),
		.control_latch_in(control_latch_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// system clock at clk/4, word clock exactly ratio system clocks
	always @(posedge clk) begin
		#1;
		div = div + 2'h1;
		if (div == 2'h2) begin
			wpos = (wpos + 1 + jump) % ratio;
			jump = 0;
		end
		system_clock_in = div[1];
		word_clock_in = wpos < ratio / 2;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 40000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [8:0] exp,
		input logic [8:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_regs(input logic [8:0] e2, input logic [8:0] e3);
		check("reg2", e2, {channel_route_sel, word_length_sel,
			output_force_zero, emphasis_filter_on, soft_silence});
		check("reg3", e3, {zero_detect_en, rate_family_sel, 3'h0,
			common_gain_sel, word_clock_invert, audio_format_sel});
	endtask
	task automatic test_reset();
		check_regs(9'h120, 9'h000);
		check("left", 9'h100, left_gain_code);
		check("right", 9'h100, right_gain_code);
		check("ratio", 9'h001, {8'h00, clock_ratio_sel});
	endtask
	task automatic test_clock();
		int i;
		repeat (9216) @(posedge clk);
		check("ratio384", 9'h001, {8'h00, clock_ratio_sel});
		check("lock", 9'h000, {8'h00, midscale_output});
		ratio = 256;
		repeat (6144) @(posedge clk);
		check("ratio256", 9'h000, {8'h00, clock_ratio_sel});
		jump = 60;
		for (i = 0; i < 2048 && midscale_output !== 1'b1; i++)
			@(posedge clk);
		check("resync", 9'h001, {8'h00, midscale_output});
		repeat (6144) @(posedge clk);
		check("relock", 9'h000, {8'h00, midscale_output});
	endtask
	task automatic test_gains();
		i_dcp_host_model.send({5'h1F, 2'h0, 1'b0, 8'h40});
		check("left", 9'h100, left_gain_code);
		i_dcp_host_model.send({5'h00, 2'h1, 1'b1, 8'h80});
		check("left", 9'h040, left_gain_code);
		check("right", 9'h080, right_gain_code);
		i_dcp_host_model.send({5'h0A, 2'h0, 1'b1, 8'hFF});
		check("left", 9'h100, left_gain_code);
		check("right", 9'h080, right_gain_code);
		i_dcp_host_model.send({5'h00, 2'h1, 1'b1, 8'h00});
		check("right", 9'h000, right_gain_code);
	endtask
	task automatic test_config();
		int i;
		int k;
		logic [15:0] w2;
		logic [15:0] w3;
		for (i = 0; i < 3; i++) begin
			w2 = {5'h00, 2'h2, 4'h6 + 4'(i), 2'(i), i == 2, i[0], i[1]};
			w3 = {5'h15, 2'h3, i[0], 2'(i), 3'h7, i[0], i[1], ~i[0]};
			i_dcp_host_model.send(w2);
			i_dcp_host_model.send(w3);
			check_regs(w2[8:0], {w3[8:6], 3'h0, w3[2:0]});
			for (k = 0; k < 1100 && wpos != 64; k++)
				@(posedge clk);
			check("left now", {8'h00, ~i[1]}, {8'h00, left_channel_now});
		end
	endtask
	task automatic test_partial();
		i_dcp_host_model.shift(16'h05FF, 8);
		repeat (20) @(posedge clk);
		check_regs(9'h115, 9'h083);
		i_dcp_host_model.send(16'h0520);
		check_regs(9'h120, 9'h083);
		// with the clock enable low a whole word must be swallowed
		@(posedge clk);
		#1 ce = 1'b0;
		i_dcp_host_model.send(16'h0400);
		check_regs(9'h120, 9'h083);
		@(posedge clk);
		#1 ce = 1'b1;
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		system_clock_in = 1'b0;
		word_clock_in = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		test_reset();
		test_clock();
		test_gains();
		test_config();
		test_partial();
		print_verdict();
	end
endmodule
bind dcp_top dcp_assertions i_dcp_assertions (.clk(clk), .rst(rst),
	.control_latch_in(control_latch_in),
	.left_gain_code(left_gain_code), .right_gain_code(right_gain_code),
	.level_update(level_update), .soft_silence(soft_silence),
	.emphasis_filter_on(emphasis_filter_on),
	.output_force_zero(output_force_zero),
	.word_length_sel(word_length_sel),
	.channel_route_sel(channel_route_sel),
	.audio_format_sel(audio_format_sel),
	.word_clock_invert(word_clock_invert),
	.common_gain_sel(common_gain_sel), .rate_family_sel(rate_family_sel),
	.zero_detect_en(zero_detect_en), .midscale_output(midscale_output));
`default_nettype wire
